// ### hdl/gisc_top.sv
`timescale 1ns/10ps
module gisc_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,

   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,

   // Serial EEPROM preset
   input wire logic ee_load,
   input wire logic [31:0] ee_gis_data,
   input wire logic [7:0] ee_mic_data,

   // Multi-purpose pins
   input wire logic [1:0] mio_i,
   output logic [1:0] mio_o,
   output logic [1:0] mio_oe_n,

   // Internal UART status
   input wire logic [7:0] uart_rx_level,
   input wire logic [7:0] uart_tx_level,
   input wire logic [5:0] uart_isr_code,
   input wire logic uart_good_data,
   input wire logic uart_wake,

   // Power management
   input wire logic pd_valid,
   output logic pme_set,
   output logic uart_pd_filter_en,

   // Host interrupt
   output logic int_n
);

   // ==========================================
   // State
   gisc_pkg::gisc_apb_st_t st_q;
   gisc_pkg::gisc_apb_st_t st_d;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [7:0] mic_q;
   logic [7:0] mic_d;
   logic multi_purpose_pin_0_ie_q;
   logic multi_purpose_pin_0_ie_d;
   logic multi_purpose_pin_1_ie_q;
   logic multi_purpose_pin_1_ie_d;
   logic pd_st_q;
   logic pd_st_d;
   logic pd_ie_q;
   logic pd_ie_d;
   logic uart_ie_q;
   logic uart_ie_d;
   logic uart_pme_q;
   logic uart_pme_d;
   logic uart_pdf_q;
   logic uart_pdf_d;
   logic [7:0] rfl_q;
   logic [7:0] tfl_q;
   logic [5:0] isr_q;
   logic good_q;
   logic pme_q;
   logic int_n_q;

   // ==========================================
   // Pin logic
   gisc_mio_if #(.N(2)) mio_bus ();

   assign mio_bus.cfg = mic_q[3:0];
   assign mio_bus.pin_i = mio_i;

   gisc_mio #(.N(2)) u_mio (
      .mclk(mclk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .m(mio_bus.pins)
   );

   // ==========================================
   // Bus decode
   wire hit_mic = (paddr == gisc_pkg::OFS_MIC);
   wire hit_umr = (paddr == gisc_pkg::OFS_UMR);
   wire hit_gis = (paddr == gisc_pkg::OFS_GIS);
   wire hit_any = hit_mic | hit_umr | hit_gis;
   wire access = psel & penable;
   // Transfer completes on the edge that sees pready high
   wire done = access & (st_q == gisc_pkg::ST_ACK);
   wire wr_done = done & pwrite;
   wire wr_mic = wr_done & hit_mic;
   wire wr_gis = wr_done & hit_gis;
   // Clear only what the host actually saw, so a late set survives
   wire pd_clr = done & ~pwrite & hit_gis & prdata_q[gisc_pkg::GIS_PD_ST];

   // ==========================================
   // Interrupt sources
   wire uart_irq = ~isr_q[0];
   wire multi_purpose_pin_0_irq = mio_bus.state[0] & multi_purpose_pin_0_ie_q;
   wire multi_purpose_pin_1_irq = mio_bus.state[1] & multi_purpose_pin_1_ie_q;
   wire pd_irq = pd_st_q & pd_ie_q;
   wire any_irq = multi_purpose_pin_0_irq | multi_purpose_pin_1_irq | (uart_irq & uart_ie_q) | pd_irq;

   // ==========================================
   // Read data
   wire [31:0] gis_rd = {
      6'h00,
      uart_pdf_q,
      uart_pme_q,
      uart_ie_q,
      uart_irq,
      pd_ie_q,
      pd_st_q,
      multi_purpose_pin_1_ie_q,
      multi_purpose_pin_0_ie_q,
      14'h0000,
      mio_bus.state[1],
      mio_bus.state[0],
      2'h0
   };
   wire [31:0] umr_rd = {
      4'h0,
      good_q,
      5'h00,
      isr_q,
      tfl_q,
      rfl_q
   };
   wire [31:0] mic_rd = {24'h000000, mic_q};
   wire [31:0] rd_mux = hit_gis ? gis_rd :
                        hit_umr ? umr_rd :
                        hit_mic ? mic_rd : 32'h00000000;

   // ==========================================
   // Next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         gisc_pkg::ST_IDLE: begin
            if (access) begin
               st_d = gisc_pkg::ST_ACK;
            end
         end
         gisc_pkg::ST_ACK: begin
            st_d = gisc_pkg::ST_IDLE;
         end
         default: begin
            st_d = gisc_pkg::ST_IDLE;
         end
      endcase
   end

   always_comb begin
      mic_d = mic_q;
      multi_purpose_pin_0_ie_d = multi_purpose_pin_0_ie_q;
      multi_purpose_pin_1_ie_d = multi_purpose_pin_1_ie_q;
      pd_ie_d = pd_ie_q;
      uart_ie_d = uart_ie_q;
      uart_pme_d = uart_pme_q;
      uart_pdf_d = uart_pdf_q;
      if (ee_load) begin
         // Loader presets the writable fields
         mic_d = ee_mic_data;
         multi_purpose_pin_0_ie_d = ee_gis_data[gisc_pkg::GIS_MULTI_PURPOSE_PIN_0_IE];
         multi_purpose_pin_1_ie_d = ee_gis_data[gisc_pkg::GIS_MULTI_PURPOSE_PIN_1_IE];
         pd_ie_d = ee_gis_data[gisc_pkg::GIS_PD_IE];
         uart_ie_d = ee_gis_data[gisc_pkg::GIS_UART_IE];
         uart_pme_d = ee_gis_data[gisc_pkg::GIS_UART_PME];
         uart_pdf_d = ee_gis_data[gisc_pkg::GIS_UART_PDF];
      end else if (wr_mic) begin
         mic_d = pwdata[7:0];
      end else if (wr_gis) begin
         // Only enable bits take writes
         multi_purpose_pin_0_ie_d = pwdata[gisc_pkg::GIS_MULTI_PURPOSE_PIN_0_IE];
         multi_purpose_pin_1_ie_d = pwdata[gisc_pkg::GIS_MULTI_PURPOSE_PIN_1_IE];
         pd_ie_d = pwdata[gisc_pkg::GIS_PD_IE];
         uart_ie_d = pwdata[gisc_pkg::GIS_UART_IE];
         uart_pme_d = pwdata[gisc_pkg::GIS_UART_PME];
         uart_pdf_d = pwdata[gisc_pkg::GIS_UART_PDF];
      end
   end

   // Set wins over the read clear
   assign pd_st_d = pd_valid | (pd_st_q & ~pd_clr);

   // ==========================================
   // Bus registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= gisc_pkg::ST_IDLE;
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (clk_en) begin
         st_q <= st_d;
         if (access && st_q == gisc_pkg::ST_IDLE) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= ~hit_any;
         end else if (done) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // Control registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mic_q <= gisc_pkg::MIC_RST;
         multi_purpose_pin_0_ie_q <= gisc_pkg::GIS_MIO_IE_RST;
         multi_purpose_pin_1_ie_q <= gisc_pkg::GIS_MIO_IE_RST;
         pd_st_q <= 1'b0;
         pd_ie_q <= gisc_pkg::GIS_PD_IE_RST;
         uart_ie_q <= gisc_pkg::GIS_UART_IE_RST;
         uart_pme_q <= gisc_pkg::GIS_UART_PME_RST;
         uart_pdf_q <= gisc_pkg::GIS_UART_PDF_RST;
      end else if (clk_en) begin
         mic_q <= mic_d;
         multi_purpose_pin_0_ie_q <= multi_purpose_pin_0_ie_d;
         multi_purpose_pin_1_ie_q <= multi_purpose_pin_1_ie_d;
         pd_st_q <= pd_st_d;
         pd_ie_q <= pd_ie_d;
         uart_ie_q <= uart_ie_d;
         uart_pme_q <= uart_pme_d;
         uart_pdf_q <= uart_pdf_d;
      end
   end

   // ==========================================
   // UART mirror
   // No pending source until the UART itself reports one
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rfl_q <= 8'h00;
         tfl_q <= 8'h00;
         isr_q <= gisc_pkg::UMR_ISR_RST;
         good_q <= gisc_pkg::UMR_GOOD_RST;
      end else if (clk_en) begin
         rfl_q <= uart_rx_level;
         tfl_q <= uart_tx_level;
         isr_q <= uart_isr_code;
         good_q <= uart_good_data;
      end
   end

   // ==========================================
   // Outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pme_q <= 1'b0;
         int_n_q <= 1'b1;
      end else if (clk_en) begin
         pme_q <= uart_wake & uart_pme_q;
         int_n_q <= ~any_irq;
      end
   end

   assign prdata = prdata_q;
   assign pready = (st_q == gisc_pkg::ST_ACK);
   assign pslverr = pslverr_q & (st_q == gisc_pkg::ST_ACK);
   assign mio_o = mio_bus.drv;
   assign mio_oe_n = mio_bus.oe_n;
   assign pme_set = pme_q;
   assign uart_pd_filter_en = uart_pdf_q;
   assign int_n = int_n_q;

endmodule : gisc_top

// ### inc/gisc_pkg.sv
package gisc_pkg;

   // ==========================================
   // Register map
   localparam logic [7:0] OFS_MIC = 8'h04;
   localparam logic [7:0] OFS_UMR = 8'h08;
   localparam logic [7:0] OFS_GIS = 8'h0c;

   // ==========================================
   // Status and control bit positions
   localparam int GIS_MULTI_PURPOSE_PIN_0_ST = 2;
   localparam int GIS_MULTI_PURPOSE_PIN_1_ST = 3;
   localparam int GIS_MULTI_PURPOSE_PIN_0_IE = 18;
   localparam int GIS_MULTI_PURPOSE_PIN_1_IE = 19;
   localparam int GIS_PD_ST = 20;
   localparam int GIS_PD_IE = 21;
   localparam int GIS_UART_ST = 22;
   localparam int GIS_UART_IE = 23;
   localparam int GIS_UART_PME = 24;
   localparam int GIS_UART_PDF = 25;
   localparam int UMR_RFL_LSB = 0;
   localparam int UMR_TFL_LSB = 8;
   localparam int UMR_ISR_LSB = 16;
   localparam int UMR_GOOD = 27;

   // ==========================================
   // Values after reset
   localparam logic GIS_MIO_IE_RST = 1'b1;
   localparam logic GIS_PD_IE_RST = 1'b0;
   localparam logic GIS_UART_IE_RST = 1'b1;
   localparam logic GIS_UART_PME_RST = 1'b0;
   localparam logic GIS_UART_PDF_RST = 1'b0;
   localparam logic [7:0] MIC_RST = 8'h00;
   localparam logic [5:0] UMR_ISR_RST = 6'h01;
   localparam logic UMR_GOOD_RST = 1'b1;

   // ==========================================
   // Pin configuration codes
   localparam logic [1:0] CFG_IN = 2'h0;
   localparam logic [1:0] CFG_INV = 2'h1;
   localparam logic [1:0] CFG_OUT0 = 2'h2;
   localparam logic [1:0] CFG_OUT1 = 2'h3;

   typedef enum logic {ST_IDLE, ST_ACK} gisc_apb_st_t;

   function automatic logic cfg_is_out(input logic [1:0] cfg);
      cfg_is_out = (cfg == CFG_OUT0) || (cfg == CFG_OUT1);
   endfunction : cfg_is_out

   // Inversion only applies to an input pin
   function automatic logic cfg_state(input logic pin, input logic [1:0] cfg);
      cfg_state = pin ^ (cfg == CFG_INV);
   endfunction : cfg_state

endpackage : gisc_pkg

// ### inc/gisc_mio_if.sv
`timescale 1ns/10ps
interface gisc_mio_if #(parameter int N = 2);
   logic [2*N-1:0] cfg;
   logic [N-1:0] pin_i;
   logic [N-1:0] state;
   logic [N-1:0] drv;
   logic [N-1:0] oe_n;
   modport ctl (output cfg, output pin_i, input state, input drv, input oe_n);
   modport pins (input cfg, input pin_i, output state, output drv, output oe_n);
endinterface : gisc_mio_if

// ### hdl/gisc_mio.sv
`timescale 1ns/10ps
module gisc_mio #(
   parameter int N = 2
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Pin group
   gisc_mio_if.pins m
);

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_pin
         wire [1:0] cfg = m.cfg[2*i+1:2*i];

         assign m.state[i] = gisc_pkg::cfg_state(m.pin_i[i], cfg);

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               m.drv[i] <= 1'b0;
               m.oe_n[i] <= 1'b1;
            end else if (clk_en) begin
               m.drv[i] <= cfg[0];
               m.oe_n[i] <= !gisc_pkg::cfg_is_out(cfg);
            end
         end
      end
   endgenerate

endmodule : gisc_mio

// ### testbench/gisc_top_asserts.sv
`timescale 1ns/10ps
module gisc_top_asserts (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Bus
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Side signals
   input wire logic ee_load,
   input wire logic [1:0] mio_o,
   input wire logic [1:0] mio_oe_n,
   input wire logic [5:0] uart_isr_code,
   input wire logic uart_wake,
   input wire logic pme_set,
   input wire logic uart_pd_filter_en
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire logic ack = psel && penable && pready && clk_en;
   wire logic a_gis = paddr == gisc_pkg::OFS_GIS;
   wire logic a_mic = paddr == gisc_pkg::OFS_MIC;
   wire logic a_umr = paddr == gisc_pkg::OFS_UMR;
   wire logic rd = ack && !pwrite;
   wire logic wr = ack && pwrite && !ee_load;
   // ==========
   // Register reads, and the error flag on every read or write
   chk_resv_zero:
   assert property (rd && a_gis |-> {prdata[31:26], prdata[17:4], prdata[1:0]} == 22'h0)
      else $error("reserved bits set");
   chk_uart_stat:
   assert property (rd && a_gis |-> prdata[22] != $past(uart_isr_code[0], 2))
      else $error("uart status wrong");
   chk_mirror_code:
   assert property (rd && a_umr |-> prdata[21:16] == $past(uart_isr_code, 2))
      else $error("mirror code wrong");
   chk_unmap_err:
   assert property (ack |-> pslverr == !(a_gis || a_mic || a_umr))
      else $error("error flag wrong");
   // ==========
   // Outputs after writes; two edges because pins lag the stored value
   chk_pin_cfg:
   assert property (wr && a_mic |-> ##2 mio_oe_n == ~{$past(pwdata[3], 2), $past(pwdata[1], 2)}
      && (mio_o | mio_oe_n) == ({$past(pwdata[2], 2), $past(pwdata[0], 2)} | mio_oe_n))
      else $error("pin drive wrong");
   chk_pdf_level:
   assert property (wr && a_gis |-> ##2 uart_pd_filter_en == $past(pwdata[25], 2))
      else $error("filter enable wrong");
   chk_pme_gate:
   assert property (clk_en && !uart_wake |=> !pme_set)
      else $error("wake event without cause");
   chk_pme_cause:
   assert property ($rose(pme_set) |-> $past(uart_wake))
      else $error("wake event late");
   cover property (rd && a_gis && prdata[20]);
   cover property (wr && a_mic);
   cover property ($rose(pme_set));
endmodule : gisc_top_asserts

// ### testbench/gisc_host_model.sv
`timescale 1ns/10ps
module gisc_host_model (
   // Bus
   input wire logic mclk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic [7:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] pwdata
);
   initial begin
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Look between edges, where the answer has settled and still stands
      @(negedge mclk);
      while (pready !== 1'b1) @(negedge mclk);
      r = prdata;
      e = pslverr;
      // The rising edge that samples pready high ends the transfer
      @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data must not look valid
      pwdata <= ~d;
   endtask : xfer
endmodule : gisc_host_model

// ### testbench/tb_gisc_top.sv
`timescale 1ns/10ps
module tb_gisc_top;
   logic mclk, rst_n, ee_load, uart_wake, pd_valid, psel, penable, pwrite, pready, pslverr;
   logic pme_set, uart_pd_filter_en, int_n, err;
   logic [7:0] paddr, ee_mic_data, rxl, cfg;
   logic [31:0] pwdata, prdata, ee_gis_data, rd, en, wr, seed;
   logic [1:0] mio_i, mio_o, mio_oe_n, ext;
   logic [5:0] uart_isr_code;
   int bad_count = 0;
   int num_checks = 0;
   // Pin wire: the block wins where it drives
   assign mio_i = (mio_o & ~mio_oe_n) | (ext & mio_oe_n);
   gisc_top u_gisc_top (.mclk, .rst_n, .clk_en(1'b1), .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .ee_load, .ee_gis_data, .ee_mic_data, .mio_i,
      .mio_o, .mio_oe_n, .uart_rx_level(rxl), .uart_tx_level(~rxl), .uart_isr_code,
      .uart_good_data(rxl[0]), .uart_wake, .pd_valid, .pme_set, .uart_pd_filter_en, .int_n);
   gisc_host_model u_gisc_host_model (.mclk, .prdata, .pready, .pslverr, .paddr, .psel,
      .penable, .pwrite, .pwdata);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [1:0] st_exp();
      for (int k = 0; k < 2; k++) begin
         st_exp[k] = cfg[2*k+1] ? cfg[2*k] : ext[k] ^ (cfg[2*k+:2] == 2'h1);
      end
   endfunction : st_exp
   function automatic logic [31:0] gis_exp(input logic pd);
      return {6'h0, en[25:23], ~uart_isr_code[0], en[21], pd, en[19:18], 14'h0, st_exp(), 2'h0};
   endfunction : gis_exp
   function automatic logic [31:0] int_exp(input logic pd);
      return {31'h0, ~|{st_exp() & en[19:18], ~uart_isr_code[0] & en[23], pd & en[21]}};
   endfunction : int_exp
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, s);
         bad_count++;
      end
   endtask : chk
   task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_gisc_host_model.xfer(w, a, d, rd, err);
   endtask : rw
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   initial begin
      repeat (5000) @(posedge mclk);
      bad_count++;
      complete_run();
   end
   // ==========
   // Main sequence
   initial begin
      {rst_n, ee_load, uart_wake, pd_valid, ext, rxl, cfg, ee_gis_data, ee_mic_data} = '0;
      seed = 32'hf2af;
      uart_isr_code = 6'h01;
      en = 32'h008c0000;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      rw(1'b0, gisc_pkg::OFS_GIS, 32'h0);
      chk("gis reset", gis_exp(1'b0), rd);
      chk("int reset", int_exp(1'b0), {31'h0, int_n});
      for (int i = 0; i < 12; i++) begin
         cfg = (i < 4) ? 8'(i * 5) : 8'(xs());
         wr = xs();
         en = wr & 32'h03ac0000;
         rw(1'b1, gisc_pkg::OFS_MIC, {24'h0, cfg});
         rw(1'b1, gisc_pkg::OFS_GIS, wr);
         rw(1'b1, gisc_pkg::OFS_UMR, xs());
         ext <= 2'(xs());
         uart_isr_code <= 6'(xs());
         rxl <= 8'(xs());
         repeat (3) @(posedge mclk);
         rw(1'b0, gisc_pkg::OFS_GIS, 32'h0);
         chk("gis", gis_exp(1'b0), rd);
         chk("int", int_exp(1'b0), {31'h0, int_n});
         chk("oe", {30'h0, ~cfg[3], ~cfg[1]}, {30'h0, mio_oe_n});
         chk("pdf", {31'h0, en[25]}, {31'h0, uart_pd_filter_en});
         rw(1'b0, gisc_pkg::OFS_UMR, 32'h0);
         chk("umr", {4'h0, rxl[0], 5'h0, uart_isr_code, ~rxl, rxl}, rd);
      end
      cfg = 8'h00;
      rw(1'b1, gisc_pkg::OFS_MIC, 32'h0);
      for (int j = 0; j < 2; j++) begin
         en = j ? 32'h01200000 : 32'h0;
         rw(1'b1, gisc_pkg::OFS_GIS, en);
         {pd_valid, uart_wake} <= 2'h3;
         @(posedge mclk);
         {pd_valid, uart_wake} <= 2'h0;
         #1;
         chk("pme", {31'h0, en[24]}, {31'h0, pme_set});
         repeat (3) @(posedge mclk);
         chk("int pd", int_exp(1'b1), {31'h0, int_n});
         rw(1'b0, gisc_pkg::OFS_GIS, 32'h0);
         chk("gis pd", gis_exp(1'b1), rd);
         rw(1'b0, gisc_pkg::OFS_GIS, 32'h0);
         chk("gis clr", gis_exp(1'b0), rd);
      end
      ee_gis_data <= xs() & 32'h03ac0000;
      ee_load <= 1'b1;
      @(posedge mclk);
      ee_load <= 1'b0;
      en = ee_gis_data;
      rw(1'b0, gisc_pkg::OFS_GIS, 32'h0);
      chk("gis preset", gis_exp(1'b0), rd);
      rw(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      complete_run();
   end
endmodule : tb_gisc_top
bind gisc_top gisc_top_asserts u_gisc_top_asserts (.mclk, .rst_n, .clk_en, .paddr, .psel,
   .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .ee_load, .mio_o, .mio_oe_n,
   .uart_isr_code, .uart_wake, .pme_set, .uart_pd_filter_en);
